// >>> hw/rdt_channel.sv
// rdt_channel: one 16-bit reload down counter with gate and pulse output.
// assumes run, mode and gate_ok are synchronous to clk.
`include "rdt_params.svh"
`default_nettype none

module rdt_channel #(
  parameter int unsigned CNT_W = `RDT_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ticks and control
  rdt_tick_if.snk ticks,
  input wire logic run,
  input wire rdt_pkg::rdt_mode_t mode,
  input wire logic gate_ok,
  // count register write
  input wire logic wr_en,
  input wire logic [CNT_W-1:0] wr_data,
  // status
  output logic [CNT_W-1:0] count,
  output logic underflow,
  output logic pulse
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] reload_reg;
  logic started_reg;
  logic underflow_reg;
  logic pulse_reg;
  logic tick_sel;
  logic counting;
  logic step;
  logic at_zero;

  always_comb begin
    case (rdt_pkg::rdt_src_t'(mode.src))
      rdt_pkg::SRC_UNDIV: tick_sel = ticks.tick[0];
      rdt_pkg::SRC_DIV2: tick_sel = ticks.tick[1];
      rdt_pkg::SRC_DIV8: tick_sel = ticks.tick[2];
      rdt_pkg::SRC_DIV32: tick_sel = ticks.tick[3];
      rdt_pkg::SRC_SUB32: tick_sel = ticks.tick[4];
      default: tick_sel = 1'b0;
    endcase
  end

  assign counting = run && (!mode.gate_en || gate_ok);
  assign step = counting && tick_sel;
  assign at_zero = count_reg == '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) started_reg <= 1'b0;
    else if (!run) started_reg <= 1'b0;
    else if (step) started_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reload_reg <= `RDT_COUNT_RESET;
    else if (wr_en) reload_reg <= wr_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) count_reg <= `RDT_COUNT_RESET;
    else if (wr_en && (!run || !started_reg)) count_reg <= wr_data;
    else if (step && at_zero) count_reg <= reload_reg;
    else if (step) count_reg <= count_reg - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) underflow_reg <= 1'b0;
    else underflow_reg <= step && at_zero;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pulse_reg <= 1'b0;
    else if (!run || !mode.pulse_en) pulse_reg <= 1'b0;
    else if (step && at_zero) pulse_reg <= !pulse_reg;
  end

  assign count = count_reg;
  assign underflow = underflow_reg;
  assign pulse = pulse_reg;

endmodule : rdt_channel

`default_nettype wire

// >>> hw/rdt_params.svh
// rdt_params.svh: offsets, field positions, reset values and divider masks
// for the reload down timer group; included by the channel, prescaler and top modules.
// Functional notes
// - count source: undivided, /2, /8, /32, subclock/32
// - decrement per tick, reload on underflow, continue
// - underflow rate is source rate over n+1
// - run bit one counts, zero stops
// - interrupt request on every underflow
// - count register read returns live counter
// - write before first tick loads reload and counter
// - write after first tick loads reload only
// - gate pin level enables or blocks counting
// - pulse pin toggles at every underflow
// - pulse pin low while timer not running
// - pins serve as port or gate/pulse function
`ifndef RDT_PARAMS_SVH
`define RDT_PARAMS_SVH

`define RDT_NUM_TIMERS 5
`define RDT_CNT_W 16
`define RDT_ADDR_W 8

`define RDT_OFS_START 8'h00
`define RDT_OFS_STAT 8'h04
`define RDT_OFS_CLR 8'h08
`define RDT_OFS_EN 8'h0c
`define RDT_OFS_PINS 8'h10
`define RDT_OFS_MODE 8'h20
`define RDT_OFS_COUNT 8'h40
`define RDT_PINS_GATE_LSB 8

`define RDT_MODE_RESET 5'h00
`define RDT_COUNT_RESET 16'h0000

`define RDT_MASK_DIV2 5'h01
`define RDT_MASK_DIV8 5'h07
`define RDT_MASK_DIV32 5'h1f

`define RDT_RESP_OKAY 2'b00
`define RDT_RESP_SLVERR 2'b10

`endif

// >>> hw/rdt_pkg.sv
// rdt_pkg: types shared by the timer group modules.
// assumes nothing beyond a standard compile order.
`default_nettype none

package rdt_pkg;

  typedef enum logic [2:0] {
    SRC_UNDIV = 3'b000,
    SRC_DIV2  = 3'b001,
    SRC_DIV8  = 3'b010,
    SRC_DIV32 = 3'b011,
    SRC_SUB32 = 3'b100
  } rdt_src_t;

  typedef struct packed {
    logic pulse_en;
    logic gate_en;
    logic [2:0] src;
  } rdt_mode_t;

endpackage : rdt_pkg

`default_nettype wire

// >>> hw/rdt_prescaler.sv
// rdt_prescaler: divided tick strobes for all count sources.
// assumes a free-running subclock pin, slow against clk.
`include "rdt_params.svh"
`default_nettype none

module rdt_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // subclock pin
  input wire logic sub_clk_pin,
  // tick outputs
  rdt_tick_if.src ticks
);

  logic [4:0] div_reg;
  logic [4:0] sub_div_reg;
  logic [2:0] sub_sync_reg;
  logic sub_level_reg;
  logic sub_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_reg <= 5'h00;
    else div_reg <= div_reg + 5'h01;
  end

  // subclock crosses domains: accept a level once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sub_sync_reg <= 3'h0;
    else sub_sync_reg <= {sub_sync_reg[1:0], sub_clk_pin};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sub_level_reg <= 1'b0;
    else if (sub_sync_reg[1] == sub_sync_reg[2])
      sub_level_reg <= sub_sync_reg[2];
  end

  assign sub_rise = (sub_sync_reg[2:1] == 2'b11) && !sub_level_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sub_div_reg <= 5'h00;
    else if (sub_rise) sub_div_reg <= sub_div_reg + 5'h01;
  end

  assign ticks.tick[0] = 1'b1;
  assign ticks.tick[1] = (div_reg & `RDT_MASK_DIV2) == `RDT_MASK_DIV2;
  assign ticks.tick[2] = (div_reg & `RDT_MASK_DIV8) == `RDT_MASK_DIV8;
  assign ticks.tick[3] = div_reg == `RDT_MASK_DIV32;
  assign ticks.tick[4] = sub_rise && (sub_div_reg == `RDT_MASK_DIV32);

endmodule : rdt_prescaler

`default_nettype wire

// >>> hw/rdt_tick_if.sv
// rdt_tick_if: one-cycle count-source ticks, indexed by source code.
// assumes producer and consumers share one clock.
`default_nettype none

interface rdt_tick_if;
  logic [4:0] tick;
  modport src (output tick);
  modport snk (input tick);
endinterface : rdt_tick_if

`default_nettype wire

// >>> hw/rdt_top.sv
// rdt_top: five reload down timers behind an AXI4-Lite register slave.
// assumes a single 100 MHz clock; gate and subclock pins are asynchronous.
`include "rdt_params.svh"
`default_nettype none

module rdt_top #(
  parameter int unsigned NUM_TIMERS = `RDT_NUM_TIMERS,
  parameter int unsigned CNT_W = `RDT_CNT_W,
  parameter bit GATE_ACTIVE_HIGH = 1'b1,
  parameter logic [4:0] MODE_RESET = `RDT_MODE_RESET
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // write address channel
  input wire logic [`RDT_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // write data channel
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // write response channel
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read address channel
  input wire logic [`RDT_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // read data channel
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // timer pins
  input wire logic [NUM_TIMERS-1:0] GATE_IN,
  input wire logic SUBCLK_IN,
  output logic [NUM_TIMERS-1:0] PULSE_OUT,
  output logic [NUM_TIMERS-1:0] PULSE_OE,
  // interrupt
  output logic IRQ
);

  localparam int unsigned N = NUM_TIMERS;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = new_w[8*b +: 8];
    end
    return res;
  endfunction : merge_strb

  function automatic logic is_mode_slot(input logic [`RDT_ADDR_W-1:0] a);
    return ((a & 8'he0) == `RDT_OFS_MODE) && (a[1:0] == 2'b00) &&
           ({29'h0, a[4:2]} < N);
  endfunction : is_mode_slot

  function automatic logic is_count_slot(input logic [`RDT_ADDR_W-1:0] a);
    return ((a & 8'he0) == `RDT_OFS_COUNT) && (a[1:0] == 2'b00) &&
           ({29'h0, a[4:2]} < N);
  endfunction : is_count_slot

  function automatic logic is_mapped(input logic [`RDT_ADDR_W-1:0] a);
    return (a == `RDT_OFS_START) || (a == `RDT_OFS_STAT) ||
           (a == `RDT_OFS_CLR) || (a == `RDT_OFS_EN) ||
           (a == `RDT_OFS_PINS) || is_mode_slot(a) || is_count_slot(a);
  endfunction : is_mapped

  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // write channel
  logic awready_reg;
  logic aw_got_reg;
  logic [`RDT_ADDR_W-1:0] awaddr_reg;
  logic wready_reg;
  logic w_got_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;

  // both halves held before the write, so either may arrive first
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) awready_reg <= 1'b0;
    else if (S_AXI_AWVALID && awready_reg) awready_reg <= 1'b0;
    else if (!aw_got_reg && !bvalid_reg) awready_reg <= 1'b1;
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      aw_got_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (S_AXI_AWVALID && awready_reg) begin
      aw_got_reg <= 1'b1;
      awaddr_reg <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) wready_reg <= 1'b0;
    else if (S_AXI_WVALID && wready_reg) wready_reg <= 1'b0;
    else if (!w_got_reg && !bvalid_reg) wready_reg <= 1'b1;
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      w_got_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID && wready_reg) begin
      w_got_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RDT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(awaddr_reg) ? `RDT_RESP_OKAY : `RDT_RESP_SLVERR;
    end else if (S_AXI_BREADY && bvalid_reg) begin
      bvalid_reg <= 1'b0;
    end
  end

  // register file
  logic [N-1:0] run_reg;
  logic [N-1:0] irq_en_reg;
  logic [N-1:0] status_reg;
  logic [N-1:0] status_next;
  logic [N-1:0] clr_mask;
  logic [N-1:0] underflow_w;
  logic [N-1:0] pulse_w;
  logic [N-1:0] pulse_oe_reg;
  logic [N-1:0] cnt_wr;
  logic [CNT_W-1:0] count_w [N];
  rdt_pkg::rdt_mode_t mode_reg [N];
  logic [31:0] wmask_zero;
  logic irq_reg;

  assign wmask_zero = merge_strb(32'h0000_0000, wdata_reg, wstrb_reg);

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) run_reg <= '0;
    else if (wr_fire && awaddr_reg == `RDT_OFS_START)
      run_reg <= N'(merge_strb({{(32-N){1'b0}}, run_reg}, wdata_reg,
                            wstrb_reg));
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) irq_en_reg <= '0;
    else if (wr_fire && awaddr_reg == `RDT_OFS_EN)
      irq_en_reg <= N'(merge_strb({{(32-N){1'b0}}, irq_en_reg}, wdata_reg,
                               wstrb_reg));
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int i = 0; i < N; i++)
        mode_reg[i] <= rdt_pkg::rdt_mode_t'(MODE_RESET);
    end else if (wr_fire && is_mode_slot(awaddr_reg)) begin
      mode_reg[awaddr_reg[4:2]] <= rdt_pkg::rdt_mode_t'(
        5'(merge_strb({27'h0, mode_reg[awaddr_reg[4:2]]}, wdata_reg,
                   wstrb_reg)));
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      cnt_wr[i] = wr_fire && is_count_slot(awaddr_reg) &&
                  ({29'h0, awaddr_reg[4:2]} == i);
    end
  end

  // a new underflow beats a clear written in the same cycle
  assign clr_mask = (wr_fire && awaddr_reg == `RDT_OFS_CLR) ?
                    wmask_zero[N-1:0] : '0;
  assign status_next = (status_reg & ~clr_mask) | underflow_w;

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) status_reg <= '0;
    else status_reg <= status_next;
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) irq_reg <= 1'b0;
    else irq_reg <= |(status_reg & irq_en_reg);
  end

  // gate pins: three stages, level accepted once stages two and three agree
  logic [N-1:0] gate_s0_reg;
  logic [N-1:0] gate_s1_reg;
  logic [N-1:0] gate_s2_reg;
  logic [N-1:0] gate_lvl_reg;
  logic [N-1:0] gate_agree;
  logic [N-1:0] gate_ok;

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gate_s0_reg <= '0;
      gate_s1_reg <= '0;
      gate_s2_reg <= '0;
    end else begin
      gate_s0_reg <= GATE_IN;
      gate_s1_reg <= gate_s0_reg;
      gate_s2_reg <= gate_s1_reg;
    end
  end

  assign gate_agree = ~(gate_s1_reg ^ gate_s2_reg);

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) gate_lvl_reg <= '0;
    else gate_lvl_reg <= (gate_lvl_reg & ~gate_agree) |
                         (gate_s2_reg & gate_agree);
  end

  assign gate_ok = GATE_ACTIVE_HIGH ? gate_lvl_reg : ~gate_lvl_reg;

  // pin function select: the pad mux uses the enable to pick the port
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) pulse_oe_reg <= '0;
    else begin
      for (int i = 0; i < N; i++)
        pulse_oe_reg[i] <= mode_reg[i].pulse_en;
    end
  end

  // timers
  rdt_tick_if tick_bus ();

  rdt_prescaler u_prescaler (
    .clk(CLK),
    .rst_n(rst_n_reg),
    .sub_clk_pin(SUBCLK_IN),
    .ticks(tick_bus.src)
  );

  for (genvar g = 0; g < N; g++) begin : g_timer
    rdt_channel #(
      .CNT_W(CNT_W)
    ) u_channel (
      .clk(CLK),
      .rst_n(rst_n_reg),
      .ticks(tick_bus.snk),
      .run(run_reg[g]),
      .mode(mode_reg[g]),
      .gate_ok(gate_ok[g]),
      .wr_en(cnt_wr[g]),
      .wr_data(CNT_W'(merge_strb({{(32-CNT_W){1'b0}}, count_w[g]}, wdata_reg,
                          wstrb_reg))),
      .count(count_w[g]),
      .underflow(underflow_w[g]),
      .pulse(pulse_w[g])
    );
  end

  // read channel
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (S_AXI_ARADDR == `RDT_OFS_START) rd_word[N-1:0] = run_reg;
    else if (S_AXI_ARADDR == `RDT_OFS_STAT) rd_word[N-1:0] = status_reg;
    else if (S_AXI_ARADDR == `RDT_OFS_EN) rd_word[N-1:0] = irq_en_reg;
    else if (S_AXI_ARADDR == `RDT_OFS_PINS) begin
      rd_word[N-1:0] = pulse_w;
      rd_word[`RDT_PINS_GATE_LSB +: N] = gate_lvl_reg;
    end else if (is_mode_slot(S_AXI_ARADDR))
      rd_word[4:0] = mode_reg[S_AXI_ARADDR[4:2]];
    else if (is_count_slot(S_AXI_ARADDR))
      rd_word[CNT_W-1:0] = count_w[S_AXI_ARADDR[4:2]];
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) arready_reg <= 1'b0;
    else if (S_AXI_ARVALID && arready_reg) arready_reg <= 1'b0;
    else if (!rvalid_reg) arready_reg <= 1'b1;
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RDT_RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= is_mapped(S_AXI_ARADDR) ? `RDT_RESP_OKAY :
                   `RDT_RESP_SLVERR;
    end else if (S_AXI_RREADY && rvalid_reg) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign PULSE_OUT = pulse_w;
  assign PULSE_OE = pulse_oe_reg;
  assign IRQ = irq_reg;

endmodule : rdt_top

`default_nettype wire

// >>> sim/rdt_pin_model.sv
// rdt_pin_model: the pins outside the timer group, gate levels and subclock.
// assumes the bench sets gate levels on clock edges.
`default_nettype none

module rdt_pin_model #(
  parameter int N = 5
) (
  // levels asked for by the bench
  input wire logic [N-1:0] gate_lvl,
  // pins
  output logic [N-1:0] gate_pin,
  output logic sub_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // free-running, 8 clock periods, offset so edges never meet the clock
  initial begin
    sub_pin = 1'b0;
    #3;
    forever #40 sub_pin = ~sub_pin;
  end

  assign gate_pin = gate_lvl;
endmodule : rdt_pin_model

`default_nettype wire

// >>> sim/rdt_tb_top.sv
// rdt_tb_top: self-checking bench for the timer group over AXI4-Lite.
// assumes rdt_pin_model and rdt_top_asserts are compiled alongside.
`include "rdt_params.svh"
`default_nettype none

module rdt_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00;
  logic [7:0] S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0;
  logic [4:0] gate_lvl = 5'h00;
  wire [4:0] GATE_IN;
  wire SUBCLK_IN;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [4:0] PULSE_OUT, PULSE_OE;
  int fail_count = 0;
  int check_count = 0;
  int seed = 70418;
  int per_cnt = 0;
  int mon_idx = 0;
  int per_mul[5] = '{1, 2, 8, 32, 256};
  logic last_pulse = 1'b0;
  logic [33:0] exp_b[$], exp_r[$], exp_per[$];

  rdt_top dut (
    .CLK(CLK), .NRST(NRST),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .GATE_IN(GATE_IN),
    .SUBCLK_IN(SUBCLK_IN), .PULSE_OUT(PULSE_OUT), .PULSE_OE(PULSE_OE),
    .IRQ(IRQ)
  );

  rdt_pin_model u_pins (
    .gate_lvl(gate_lvl), .gate_pin(GATE_IN), .sub_pin(SUBCLK_IN)
  );

  initial begin
    forever #5 CLK = ~CLK;
  end

  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    exp_b.push_back({32'h0, r});
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    exp_r.push_back({r, d});
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
  endtask : axi_rd

  // results are taken off the queues in the order they were promised
  always @(posedge CLK) begin
    if (S_AXI_BVALID && S_AXI_BREADY)
      check("bresp", {32'h0, S_AXI_BRESP}, exp_b.pop_front());
    if (S_AXI_RVALID && S_AXI_RREADY)
      check("rdata", {S_AXI_RRESP, S_AXI_RDATA}, exp_r.pop_front());
    if (PULSE_OUT[mon_idx] !== last_pulse) begin
      if (exp_per.size() > 0)
        check("period", 34'(per_cnt), exp_per.pop_front());
      per_cnt = 1;
    end else begin
      per_cnt++;
    end
    last_pulse = PULSE_OUT[mon_idx];
  end

  initial begin
    repeat (80000) @(posedge CLK);
    fail_count++;
    end_sim;
  end

  initial begin
    int k, t;
    logic [15:0] n, v;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CLK);
    for (k = 0; k < 5; k++) begin
      axi_rd(8'(4 * k), 32'h0, `RDT_RESP_OKAY);
      axi_rd(`RDT_OFS_MODE + 8'(4 * k), 32'h0, `RDT_RESP_OKAY);
      axi_rd(`RDT_OFS_COUNT + 8'(4 * k), 32'h0, `RDT_RESP_OKAY);
    end
    axi_wr(8'h14, 32'hffff, `RDT_RESP_SLVERR);
    axi_wr(8'h02, 32'hffff, `RDT_RESP_SLVERR);
    axi_rd(8'h02, 32'h0, `RDT_RESP_SLVERR);
    axi_rd(8'h34, 32'h0, `RDT_RESP_SLVERR);
    axi_wr(`RDT_OFS_STAT, 32'h1f, `RDT_RESP_OKAY);
    axi_rd(`RDT_OFS_STAT, 32'h0, `RDT_RESP_OKAY);
    for (k = 0; k < 5; k++) begin
      v = 16'($random(seed));
      axi_wr(`RDT_OFS_COUNT + 8'(4 * k), {16'h0, v}, `RDT_RESP_OKAY);
      axi_rd(`RDT_OFS_COUNT + 8'(4 * k), {16'h0, v}, `RDT_RESP_OKAY);
    end
    // timer k on source k, so every timer and every source gets a turn
    for (k = 0; k < 5; k++) begin
      n = 16'($random(seed)) & 16'h0003;
      mon_idx = k;
      axi_wr(`RDT_OFS_MODE + 8'(4 * k), 32'h10 | k, `RDT_RESP_OKAY);
      axi_wr(`RDT_OFS_COUNT + 8'(4 * k), {16'h0, n}, `RDT_RESP_OKAY);
      axi_wr(`RDT_OFS_EN, 32'h1 << k, `RDT_RESP_OKAY);
      axi_wr(`RDT_OFS_START, 32'h1 << k, `RDT_RESP_OKAY);
      for (t = 0; t < 3000 && PULSE_OUT[k] !== 1'b1; t++) @(posedge CLK);
      #1;
      repeat (3) exp_per.push_back(34'(per_mul[k] * (n + 1)));
      for (t = 0; t < 5000 && exp_per.size() > 0; t++) @(posedge CLK);
      check("periods", 34'(exp_per.size()), 34'h0);
      check("oe", {33'h0, PULSE_OE[k]}, 34'h1);
      axi_wr(`RDT_OFS_START, 32'h0, `RDT_RESP_OKAY);
      repeat (2) @(posedge CLK);
      axi_rd(`RDT_OFS_PINS, 32'h0, `RDT_RESP_OKAY);
      axi_rd(`RDT_OFS_STAT, 32'h1 << k, `RDT_RESP_OKAY);
      check("irq", {33'h0, IRQ}, 34'h1);
      axi_wr(`RDT_OFS_EN, 32'h0, `RDT_RESP_OKAY);
      repeat (2) @(posedge CLK);
      check("irq", {33'h0, IRQ}, 34'h0);
      axi_wr(`RDT_OFS_CLR, 32'h1 << k, `RDT_RESP_OKAY);
      axi_rd(`RDT_OFS_STAT, 32'h0, `RDT_RESP_OKAY);
    end
    // gated timer 1: count only while the pin is high
    axi_wr(`RDT_OFS_MODE + 8'h04, 32'h08, `RDT_RESP_OKAY);
    axi_wr(`RDT_OFS_START, 32'h02, `RDT_RESP_OKAY);
    v = 16'($random(seed)) | 16'h8000;
    axi_wr(`RDT_OFS_COUNT + 8'h04, {16'h0, v}, `RDT_RESP_OKAY);
    axi_rd(`RDT_OFS_COUNT + 8'h04, {16'h0, v}, `RDT_RESP_OKAY);
    t = 5 + ($random(seed) & 15);
    gate_lvl[1] <= 1'b1;
    repeat (t) @(posedge CLK);
    gate_lvl[1] <= 1'b0;
    repeat (8) @(posedge CLK);
    v = v - 16'(t);
    axi_rd(`RDT_OFS_COUNT + 8'h04, {16'h0, v}, `RDT_RESP_OKAY);
    axi_wr(`RDT_OFS_COUNT + 8'h04, 32'h1234, `RDT_RESP_OKAY);
    axi_rd(`RDT_OFS_COUNT + 8'h04, {16'h0, v}, `RDT_RESP_OKAY);
    axi_wr(`RDT_OFS_START, 32'h0, `RDT_RESP_OKAY);
    end_sim;
  end
endmodule : rdt_tb_top

`default_nettype wire

// >>> sim/rdt_top_asserts.sv
// rdt_top_asserts: bus handshake, pulse pin and interrupt checks on rdt_top.
// assumes the master offers write address and data together, full strobes.
`include "rdt_params.svh"
`default_nettype none

module rdt_top_asserts #(
  parameter int unsigned NUM_TIMERS = `RDT_NUM_TIMERS
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // write side
  input wire logic [`RDT_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read side
  input wire logic [`RDT_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // pins and interrupt
  input wire logic [NUM_TIMERS-1:0] PULSE_OUT,
  input wire logic [NUM_TIMERS-1:0] PULSE_OE,
  input wire logic IRQ
);
  // shadow moves one edge before the real enable, so waits carry slack
  logic [NUM_TIMERS-1:0] en_shadow_reg;
  logic wr_take;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  assign wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
                   S_AXI_WREADY;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      en_shadow_reg <= '0;
    end else if (wr_take && S_AXI_AWADDR == `RDT_OFS_EN) begin
      en_shadow_reg <= S_AXI_WDATA[NUM_TIMERS-1:0];
    end
  end

  sequence s_wr_take;
    wr_take;
  endsequence
  sequence s_ready_back(sig);
    !sig ##1 sig;
  endsequence

  property p_wr_answer;
    s_wr_take |-> ##2 S_AXI_BVALID;
  endproperty
  property p_rd_answer;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  property p_wr_ready_back;
    S_AXI_BVALID && S_AXI_BREADY |=> s_ready_back(S_AXI_AWREADY);
  endproperty
  property p_rd_ready_back;
    S_AXI_RVALID && S_AXI_RREADY |=> s_ready_back(S_AXI_ARREADY);
  endproperty
  property p_wr_misaligned;
    s_wr_take ##0 S_AXI_AWADDR[1:0] != 2'b00 |-> ##2
      S_AXI_BRESP == `RDT_RESP_SLVERR;
  endproperty
  property p_rd_misaligned;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[1:0] != 2'b00 |=>
      S_AXI_RRESP == `RDT_RESP_SLVERR && S_AXI_RDATA == 32'h0;
  endproperty
  property p_pulse_idle;
    (PULSE_OUT & ~PULSE_OE & ~$past(PULSE_OE)) == '0;
  endproperty
  property p_irq_event;
    |(PULSE_OUT & ~$past(PULSE_OUT) & en_shadow_reg) |-> ##2 IRQ;
  endproperty
  property p_irq_masked;
    en_shadow_reg == '0 [*4] |-> !IRQ;
  endproperty

  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data late");
  a_wr_ready_back: assert property (p_wr_ready_back)
    else $error("write ready not back after one idle cycle");
  a_rd_ready_back: assert property (p_rd_ready_back)
    else $error("read ready not back after one idle cycle");
  a_wr_misaligned: assert property (p_wr_misaligned)
    else $error("misaligned write not refused");
  a_rd_misaligned: assert property (p_rd_misaligned)
    else $error("misaligned read not refused");
  a_pulse_idle: assert property (p_pulse_idle)
    else $error("pulse pin high while not a pulse output");
  a_irq_event: assert property (p_irq_event)
    else $error("underflow did not raise the interrupt");
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt high with all sources masked");
endmodule : rdt_top_asserts

bind rdt_top rdt_top_asserts #(.NUM_TIMERS(NUM_TIMERS)) u_asserts (
  .CLK(CLK), .NRST(NRST),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .PULSE_OUT(PULSE_OUT), .PULSE_OE(PULSE_OE), .IRQ(IRQ)
);

`default_nettype wire
